// *** rtl/rshpc_consts.svh ***
`ifndef RSHPC_CONSTS_SVH
`define RSHPC_CONSTS_SVH

// ==========================================================================
// Committed control word layout
`define RSHPC_CTRL_W 16
`define RSHPC_CTRL_RESET 16'h0000
`define RSHPC_REF_AUTO_BIT 0
`define RSHPC_HOLD_AUTO_BIT 1
`define RSHPC_STAT_DIR_LSB 2
`define RSHPC_STAT_FUNC_LSB 6
`define RSHPC_STAT_FUNC_W 2
`define RSHPC_STAT_PINS 4

// ==========================================================================
// Status pin function codes
`define RSHPC_FUNC_HOLDOVER 2'h0
`define RSHPC_FUNC_REFERENCE 2'h1
`define RSHPC_FUNC_FIRST_LOST 2'h2
`define RSHPC_FUNC_SECOND_LOST 2'h3

// ==========================================================================
// Timing
`define RSHPC_CLK_PERIOD_NS 10
`define RSHPC_POR_TIME_NS 10000

`endif

// *** rtl/rshpc_pkg.sv ***
`default_nettype none

package rshpc_pkg;

   // Chip-level operating state
   typedef enum logic [1:0]
   {
      ST_RESET,
      ST_RUN,
      ST_LOW_POWER
   } rshpc_state_t;

endpackage

`default_nettype wire

// *** rtl/rshpc_sync_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Pin levels into the synchroniser and their clean copies out
interface rshpc_sync_if
#(
   parameter int W = 9
);
   logic [W-1:0] raw;
   logic [W-1:0] synced;

   modport sync_side
   (
      input raw,
      output synced
   );

   modport user_side
   (
      output raw,
      input synced
   );
endinterface

`default_nettype wire

// *** rtl/rshpc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Two-flop synchroniser; the first stage feeds only the second
module rshpc_sync
#(
   parameter int W = 9
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Pin levels
   rshpc_sync_if.sync_side pins
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1 <= '0;
         stage2 <= '0;
      end
      else
      begin
         stage1 <= pins.raw;
         stage2 <= stage1;
      end
   end

   assign pins.synced = stage2;

endmodule // rshpc_sync

`default_nettype wire

// *** rtl/rshpc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "rshpc_consts.svh"

// Contract
// [RULE1] Manual switching: choice pin input; automatic: driven
// [RULE2] Choice pin low first, high second reference
// [RULE3] Manual holdover follows high holdover pin
// [RULE4] Automatic holdover: pin reports holdover status
// [RULE5] Low-power request holds device inactive
// [RULE6] Reset pin holds all logic reset; status_pins_sampled still tracks the status pins during it
// [RULE7] Power-up makes 10 us internal reset
// [RULE8] Buffer copied only on strobe rising edge
// [RULE9] Strobe moves buffer into active controls
// [RULE10] Status pin direction, function from configuration
// [RULE11] Defaults after reset; drive pins afterwards
module rshpc_top
#(
   parameter int CTRL_W = `RSHPC_CTRL_W
)
(
   // Clock and supply-threshold reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control pins
   input wire logic chip_reset_pin,
   input wire logic low_power_request,
   input wire logic update_strobe_pin,
   // Reference choice pin
   input wire logic reference_choice_pin_in,
   output logic reference_choice_pin_out,
   output logic reference_choice_pin_oe_b,
   // Holdover pin
   input wire logic holdover_pin_in,
   output logic holdover_pin_out,
   output logic holdover_pin_oe_b,
   // Configurable status pins
   input wire logic [3:0] configurable_status_pins_in,
   output logic [3:0] configurable_status_pins_out,
   output logic [3:0] configurable_status_pins_oe_b,
   // Serial buffer and loop status, same clock
   input wire logic [CTRL_W-1:0] serial_buffer,
   input wire logic auto_reference_choice,
   input wire logic auto_holdover_request,
   input wire logic first_reference_lost,
   input wire logic second_reference_lost,
   // Core state
   output logic [CTRL_W-1:0] active_control,
   output logic active_reference,
   output logic holdover_active,
   output logic core_reset,
   output logic core_low_power,
   output logic [3:0] status_pins_sampled
);

   // =======================================================================
   // Timing
   localparam int POR_CYCLES = (`RSHPC_POR_TIME_NS
      + `RSHPC_CLK_PERIOD_NS - 1) / `RSHPC_CLK_PERIOD_NS;
   localparam int POR_W = $clog2(POR_CYCLES + 1);
   localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);
   localparam int SW = 9;

   // =======================================================================
   // Pin synchronisation
   rshpc_sync_if #(.W(SW)) pin_if ();

   assign pin_if.raw = {configurable_status_pins_in, holdover_pin_in,
      reference_choice_pin_in, update_strobe_pin, low_power_request,
      chip_reset_pin};

   rshpc_sync #(.W(SW)) u_sync
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pins(pin_if.sync_side)
   );

   wire logic reset_pin_s = pin_if.synced[0];
   wire logic low_power_s = pin_if.synced[1];
   wire logic strobe_s = pin_if.synced[2];
   wire logic choice_pin_s = pin_if.synced[3];
   wire logic holdover_pin_s = pin_if.synced[4];
   wire logic [3:0] status_pins_s = pin_if.synced[8:5];

   // =======================================================================
   // Power-up reset pulse
   logic [POR_W-1:0] por_count;
   logic por_done;
   wire logic por_end = (por_count == POR_LAST);

   // Counts from supply-threshold release, no pin action needed
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         por_count <= '0;
         por_done <= 1'b0;
      end
      else if (!por_done)
      begin
         por_count <= por_count + POR_W'(1);  // [RULE7]
         por_done <= por_end;  // [RULE7]
      end
   end

   // =======================================================================
   // Operating state
   rshpc_pkg::rshpc_state_t state;
   rshpc_pkg::rshpc_state_t next_state;

   wire logic reset_req = !por_done || reset_pin_s;  // [RULE6] [RULE7]

   always_comb
   begin
      case (state)
         rshpc_pkg::ST_RESET,
         rshpc_pkg::ST_RUN,
         rshpc_pkg::ST_LOW_POWER:
         begin
            if (reset_req)
               next_state = rshpc_pkg::ST_RESET;  // [RULE6]
            else if (low_power_s)
               next_state = rshpc_pkg::ST_LOW_POWER;  // [RULE5]
            else
               next_state = rshpc_pkg::ST_RUN;  // [RULE11]
         end
         default:
            next_state = rshpc_pkg::ST_RESET;
      endcase
   end

   wire logic next_in_reset = (next_state == rshpc_pkg::ST_RESET);
   wire logic next_low_power = (next_state == rshpc_pkg::ST_LOW_POWER);

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= rshpc_pkg::ST_RESET;
         core_reset <= 1'b1;
         core_low_power <= 1'b0;
      end
      else
      begin
         state <= next_state;
         core_reset <= next_in_reset;  // [RULE6]
         core_low_power <= next_low_power;  // [RULE5]
      end
   end

   // =======================================================================
   // Update strobe and control commit
   logic strobe_d;
   // Edge taken on the synced level, so a slow strobe commits once per rise;
   // a bouncy strobe commits again for each bounce the synchroniser samples
   wire logic strobe_rise = strobe_s && !strobe_d;  // [RULE8]

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         strobe_d <= 1'b0;
      else
         strobe_d <= strobe_s;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         active_control <= CTRL_W'(`RSHPC_CTRL_RESET);
      else if (reset_req)
         active_control <= CTRL_W'(`RSHPC_CTRL_RESET);  // [RULE11]
      else if (strobe_rise)
         active_control <= serial_buffer;  // [RULE8] [RULE9]
   end

   // =======================================================================
   // Reference choice and holdover
   wire logic ref_auto = active_control[`RSHPC_REF_AUTO_BIT];
   wire logic hold_auto = active_control[`RSHPC_HOLD_AUTO_BIT];

   // Pin low picks the first reference, high the second
   wire logic next_reference = ref_auto ? auto_reference_choice
      : choice_pin_s;  // [RULE1] [RULE2]
   wire logic next_holdover = hold_auto ? auto_holdover_request
      : holdover_pin_s;  // [RULE3] [RULE4]

   // Pins stay released until reset is over
   wire logic drive_ok = !next_in_reset;  // [RULE11]
   wire logic next_choice_oe_b = !(ref_auto && drive_ok);  // [RULE1]
   wire logic next_hold_oe_b = !(hold_auto && drive_ok);  // [RULE4]

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         active_reference <= 1'b0;
         holdover_active <= 1'b0;
         reference_choice_pin_out <= 1'b0;
         reference_choice_pin_oe_b <= 1'b1;
         holdover_pin_out <= 1'b0;
         holdover_pin_oe_b <= 1'b1;
      end
      else
      begin
         active_reference <= drive_ok && next_reference;  // [RULE2]
         holdover_active <= drive_ok && next_holdover;  // [RULE3]
         reference_choice_pin_out <= drive_ok && next_reference;  // [RULE2]
         reference_choice_pin_oe_b <= next_choice_oe_b;  // [RULE1]
         holdover_pin_out <= drive_ok && next_holdover;  // [RULE4]
         holdover_pin_oe_b <= next_hold_oe_b;  // [RULE4]
      end
   end

   // =======================================================================
   // Configurable status pins
   wire logic [3:0] stat_src;
   wire logic [3:0] stat_dir;

   genvar i;
   generate
      for (i = 0; i < `RSHPC_STAT_PINS; i++)
      begin : g_stat
         wire logic [`RSHPC_STAT_FUNC_W-1:0] func = active_control[
            `RSHPC_STAT_FUNC_LSB + i * `RSHPC_STAT_FUNC_W +:
            `RSHPC_STAT_FUNC_W];
         assign stat_dir[i] = active_control[`RSHPC_STAT_DIR_LSB + i];
         assign stat_src[i] =
            (func == `RSHPC_FUNC_HOLDOVER) ? next_holdover :
            (func == `RSHPC_FUNC_REFERENCE) ? next_reference :
            (func == `RSHPC_FUNC_FIRST_LOST) ? first_reference_lost :
            second_reference_lost;  // [RULE10]
      end
   endgenerate

   wire logic [3:0] next_stat_oe_b = ~(stat_dir & {4{drive_ok}});

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         configurable_status_pins_out <= 4'h0;
         configurable_status_pins_oe_b <= 4'hf;
         status_pins_sampled <= 4'h0;
      end
      else
      begin
         configurable_status_pins_out <= stat_src & {4{drive_ok}};
         configurable_status_pins_oe_b <= next_stat_oe_b;  // [RULE10]
         // Input-direction pins are reported, driven ones read as zero
         status_pins_sampled <= status_pins_s & ~stat_dir;  // [RULE10]
      end
   end

endmodule // rshpc_top

`default_nettype wire

// *** dv/rshpc_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Pin behaviour checks on the top ports
module rshpc_checker
#(
   parameter int CTRL_W = 16
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control inputs
   input wire logic chip_reset_pin,
   input wire logic low_power_request,
   input wire logic update_strobe_pin,
   input wire logic holdover_pin_in,
   input wire logic [CTRL_W-1:0] serial_buffer,
   input wire logic auto_reference_choice,
   // Device outputs
   input wire logic reference_choice_pin_out,
   input wire logic reference_choice_pin_oe_b,
   input wire logic [3:0] configurable_status_pins_oe_b,
   input wire logic [CTRL_W-1:0] active_control,
   input wire logic holdover_active,
   input wire logic core_reset,
   input wire logic core_low_power
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   int unsigned por_cnt;
   // Saturates so it never wraps back under the pulse length
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         por_cnt <= 0;
      else if (por_cnt < 2000)
         por_cnt <= por_cnt + 1;
   sequence s_strobe_rise;
      $rose(update_strobe_pin) && !core_reset ##1 update_strobe_pin[*3];
   endsequence
   a_por_pulse_hold: assert property (
      por_cnt < 1000 |-> core_reset)
      else $error("core reset ended before power-up pulse");
   a_ref_manual_hiz: assert property (
      (!active_control[0])[*2] |-> reference_choice_pin_oe_b)
      else $error("choice pin driven in manual mode");
   a_ref_auto_drive: assert property (
      (active_control[0] && !core_reset)[*2] |-> !reference_choice_pin_oe_b
      && reference_choice_pin_out == $past(auto_reference_choice))
      else $error("choice pin not reporting reference");
   a_hold_manual_force: assert property (
      (holdover_pin_in && !active_control[1] && !core_reset)[*5]
      |-> holdover_active)
      else $error("forced holdover not entered");
   a_low_power_entry: assert property (
      (low_power_request && !core_reset)[*5] |-> core_low_power)
      else $error("low power not entered");
   a_chip_reset_hold: assert property (
      chip_reset_pin[*5] |-> core_reset && active_control == '0
      && reference_choice_pin_oe_b && &configurable_status_pins_oe_b)
      else $error("chip reset not holding logic");
   a_strobe_only_edge: assert property (
      (!update_strobe_pin && !chip_reset_pin)[*4] |-> $stable(active_control))
      else $error("control changed without strobe");
   a_strobe_commit_word: assert property (
      s_strobe_rise |-> active_control == $past(serial_buffer))
      else $error("strobe did not commit buffer");
   a_status_dir_cfg: assert property (
      ($stable(active_control) && !core_reset)[*2]
      |-> configurable_status_pins_oe_b == ~active_control[5:2])
      else $error("status pin direction not from control");
endmodule // rshpc_checker
bind rshpc_top rshpc_checker #(.CTRL_W(CTRL_W)) u_chk
(
   .clk_sys, .rst_b, .chip_reset_pin, .low_power_request,
   .update_strobe_pin, .holdover_pin_in, .serial_buffer,
   .auto_reference_choice, .reference_choice_pin_out,
   .reference_choice_pin_oe_b, .configurable_status_pins_oe_b,
   .active_control, .holdover_active, .core_reset, .core_low_power
);
`default_nettype wire

// *** dv/rshpc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Board side: drives each pin whenever the device lets go
module rshpc_host_model
(
   // Device side of the pins
   input wire logic ref_o,
   input wire logic ref_e,
   input wire logic hold_o,
   input wire logic hold_e,
   input wire logic [3:0] st_o,
   input wire logic [3:0] st_e,
   // Board requests
   input wire logic h_ref,
   input wire logic h_hold,
   input wire logic [3:0] h_st,
   // Resolved pin levels
   output logic ref_w,
   output logic hold_w,
   output logic [3:0] st_w
);
   // Board yields while the device drives, so no contention
   assign ref_w = ref_e ? h_ref : ref_o;
   assign hold_w = hold_e ? h_hold : hold_o;
   assign st_w = (st_e & h_st) | (~st_e & st_o);
endmodule // rshpc_host_model
`default_nettype wire

// *** dv/rshpc_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module rshpc_top_tb;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic chip_reset_pin = 1'b0;
   logic low_power_request = 1'b0;
   logic update_strobe_pin = 1'b0;
   logic h_ref = 1'b0;
   logic h_hold = 1'b0;
   logic a_ref = 1'b0;
   logic a_hold = 1'b0;
   logic lost1 = 1'b0;
   logic lost2 = 1'b0;
   logic [3:0] h_st = 4'h0;
   logic [15:0] serial_buffer = 16'h0000;
   logic [15:0] last_w = 16'h0000;
   logic [15:0] exp_q[$];
   logic ref_w, ref_o, ref_e, hold_w, hold_o, hold_e, act_ref, act_hold;
   logic core_reset, core_low_power;
   logic [3:0] st_w, st_o, st_e, st_smp;
   logic [15:0] active_control;
   int n_errors = 0;
   int total_checks = 0;
   rshpc_top dut
   (
      .clk_sys, .rst_b, .chip_reset_pin, .low_power_request,
      .update_strobe_pin, .reference_choice_pin_in(ref_w),
      .reference_choice_pin_out(ref_o), .reference_choice_pin_oe_b(ref_e),
      .holdover_pin_in(hold_w), .holdover_pin_out(hold_o),
      .holdover_pin_oe_b(hold_e), .configurable_status_pins_in(st_w),
      .configurable_status_pins_out(st_o),
      .configurable_status_pins_oe_b(st_e), .serial_buffer,
      .auto_reference_choice(a_ref), .auto_holdover_request(a_hold),
      .first_reference_lost(lost1), .second_reference_lost(lost2),
      .active_control, .active_reference(act_ref),
      .holdover_active(act_hold), .core_reset, .core_low_power,
      .status_pins_sampled(st_smp)
   );
   rshpc_host_model host
   (
      .ref_o, .ref_e, .hold_o, .hold_e, .st_o, .st_e, .h_ref, .h_hold,
      .h_st, .ref_w, .hold_w, .st_w
   );
   always #5 clk_sys = ~clk_sys;
   task check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (n_errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ========================================================
   // Monitor: every change of the committed word needs a note
   always @(active_control)
      if (rst_b === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(16'h0001, 16'h0000);
         else
            check(active_control, exp_q.pop_front());
      end
   task commit(input logic [15:0] w);
      @(posedge clk_sys);
      serial_buffer <= w;
      update_strobe_pin <= 1'b1;
      if (w !== last_w)
         exp_q.push_back(w);
      last_w = w;
      repeat (4) @(posedge clk_sys);
      // Falling strobe and a fresh buffer must leave the word alone
      update_strobe_pin <= 1'b0;
      serial_buffer <= ~w;
      repeat (4) @(posedge clk_sys);
   endtask
   task mix(input int n);
      logic [15:0] w;
      logic [3:0] src;
      logic r, h;
      for (int k = 0; k < n; k++)
      begin
         w = 16'($urandom);
         commit(w);
         for (int j = 0; j < 3; j++)
         begin
            @(posedge clk_sys);
            {a_ref, a_hold, lost1, lost2, h_ref, h_hold, h_st} <=
               10'($urandom);
            repeat (5) @(posedge clk_sys);
            #1;
            r = w[0] ? a_ref : h_ref;
            h = w[1] ? a_hold : h_hold;
            src = {lost2, lost1, r, h};
            check({hold_e, ref_e}, {~w[1:0]});
            check({act_hold, act_ref}, {h, r});
            check({hold_w, ref_w}, {h, r});
            check(st_e, {~w[5:2]});
            for (int i = 0; i < 4; i++)
               if (w[2+i])
                  check(st_o[i], src[w[6+2*i+:2]]);
               else
                  check(st_smp[i], h_st[i]);
         end
      end
   endtask
   initial
   begin
      int i;
      void'($urandom(3949));
      repeat (16) @(posedge clk_sys);
      check({ref_e, hold_e, st_e, core_reset}, 7'h7f);
      rst_b <= 1'b1;
      for (i = 0; i < 1100 && core_reset !== 1'b0; i++)
      begin
         @(posedge clk_sys);
         #1;
      end
      check(i >= 1000 && i <= 1004, 1'b1);
      if (i == 1100)
         conclude();
      mix(12);
      @(posedge clk_sys);
      low_power_request <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1 check(core_low_power, 1'b1);
      @(posedge clk_sys);
      low_power_request <= 1'b0;
      repeat (5) @(posedge clk_sys);
      #1 check(core_low_power, 1'b0);
      @(posedge clk_sys);
      chip_reset_pin <= 1'b1;
      if (last_w !== 16'h0000)
         exp_q.push_back(16'h0000);
      last_w = 16'h0000;
      repeat (6) @(posedge clk_sys);
      #1 check({core_reset, ref_e, hold_e, st_e, act_ref}, 8'hfe);
      @(posedge clk_sys);
      chip_reset_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      #1 check(core_reset, 1'b0);
      mix(6);
      repeat (4) @(posedge clk_sys);
      // A note still queued means a commit never showed up
      check(16'(exp_q.size()), 16'h0000);
      conclude();
   end
endmodule // rshpc_top_tb
`default_nettype wire
